// *** rtl/mcr_core_regs.sv ***
// Core registers, program counter, banked flags and machine cycle
`timescale 1ns/1ps
module mcr_core_regs
  import mcr_pkg::*;
#(
  parameter int DIV = MCYC_DIV              // Clocks per machine cycle
) (
  input  wire logic                i_clk,         // 40 MHz clock
  input  wire logic                i_rst,         // Sync reset, high
  // Sequencer control, taken on the machine-cycle strobe
  input  wire mcr_pc_op_t          i_pc_op,       // Next-address source
  input  wire logic [PC_W-1:0]     i_pc_target,   // Jump/call/vector
  input  wire logic [7:0]          i_rel_offset,  // Signed branch offset
  input  wire logic                i_c_we,        // Update active carry
  input  wire logic                i_c_val,       // New carry value
  input  wire logic                i_z_we,        // Update active zero
  input  wire logic [DATA_W-1:0]   i_alu_result,  // Result for zero test
  // Direct accumulator write, any clock
  input  wire logic                i_acc_we,      // Accumulator load
  input  wire logic [DATA_W-1:0]   i_acc_wdata,   // Accumulator data
  // Data-space access, any clock
  input  wire logic [7:0]          i_ds_addr,     // Data address
  input  wire logic                i_ds_wr,       // Write strobe
  input  wire logic                i_ds_rd,       // Read strobe
  input  wire logic [DATA_W-1:0]   i_ds_wdata,    // Write data
  output logic [DATA_W-1:0]        o_ds_rdata,    // Read data, next clock
  output logic                     o_ds_hit,      // Read hit core reg
  // Program bank select
  input  wire logic                i_bank_we,     // Bank load
  input  wire logic [BANK_W-1:0]   i_bank_wdata,  // Bank value
  // Visible state
  output logic                     o_mcycle,      // Machine-cycle strobe
  output logic [PC_W-1:0]          o_pc,          // Program counter
  output logic [BANK_W+PC_W-1:0]   o_prog_addr,   // Bank and PC
  output mcr_ctx_t                 o_ctx,         // Active context
  output logic                     o_carry,       // Active carry
  output logic                     o_zero,        // Active zero
  output logic [DATA_W-1:0]        o_acc,         // Accumulator
  output logic [DATA_W-1:0]        o_idx_first,   // Pointer one
  output logic [DATA_W-1:0]        o_idx_second,  // Pointer two
  output logic [DATA_W-1:0]        o_shd_first,   // Short-direct one
  output logic [DATA_W-1:0]        o_shd_second,  // Short-direct two
  output logic [DEPTH_W-1:0]       o_stack_depth  // Stack levels held
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // True for the five mapped core addresses
  function automatic logic is_core_addr(input logic [7:0] a);
    return a == ADDR_ACC || a == ADDR_IDX_FIRST ||
           a == ADDR_IDX_SECOND || a == ADDR_SHD_FIRST ||
           a == ADDR_SHD_SECOND;
  endfunction : is_core_addr

  // Plain increment, shared by fetch and empty-stack return
  function automatic logic [PC_W-1:0] pc_plus_one(
    input logic [PC_W-1:0] p);
    return p + 12'h001;
  endfunction : pc_plus_one

  mcr_stk_if stk ();                      // Stack link

  mcr_ret_stack u_stack (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .s     (stk.stack)
  );

  // ---- Machine-cycle divider
  logic [DIV_W-1:0] div_cnt;              // Clock position in cycle
  logic [DIV_W-1:0] next_div_cnt;
  logic             strobe;               // Last clock of the cycle

  assign strobe   = (div_cnt == DIV_W'(DIV - 1));
  assign o_mcycle = strobe;

  // Wrap every DIV clocks; all sequencing steps on the strobe
  always_comb begin
    next_div_cnt = strobe ? '0 : div_cnt + 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ---- Data registers
  logic [DATA_W-1:0] acc, idx1, idx2, shd1, shd2;   // Core registers
  logic [DATA_W-1:0] next_acc, next_idx1, next_idx2;
  logic [DATA_W-1:0] next_shd1, next_shd2;
  logic [BANK_W-1:0] bank, next_bank;               // Program bank

  // Writes land at once so the next instruction sees them
  always_comb begin
    next_acc  = acc;
    next_idx1 = idx1;
    next_idx2 = idx2;
    next_shd1 = shd1;
    next_shd2 = shd2;
    next_bank = i_bank_we ? i_bank_wdata : bank;
    if (i_ds_wr && is_core_addr(i_ds_addr)) begin
      case (i_ds_addr)
        ADDR_ACC:        next_acc  = i_ds_wdata;
        ADDR_IDX_FIRST:  next_idx1 = i_ds_wdata;
        ADDR_IDX_SECOND: next_idx2 = i_ds_wdata;
        ADDR_SHD_FIRST:  next_shd1 = i_ds_wdata;
        ADDR_SHD_SECOND: next_shd2 = i_ds_wdata;
        default: ;                                  // Not ours
      endcase
    end
    // Direct load wins: ALU writeback is the newer value
    if (i_acc_we) begin
      next_acc = i_acc_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc  <= REG_RST;
      idx1 <= REG_RST;
      idx2 <= REG_RST;
      shd1 <= REG_RST;
      shd2 <= REG_RST;
      bank <= BANK_RST;
    end else begin
      acc  <= next_acc;
      idx1 <= next_idx1;
      idx2 <= next_idx2;
      shd1 <= next_shd1;
      shd2 <= next_shd2;
      bank <= next_bank;
    end
  end

  // ---- Data-space read port
  logic [DATA_W-1:0] next_rdata;          // Read mux
  logic              next_hit;            // Address matched

  // Reads return old contents; a same-clock write shows next read
  always_comb begin
    next_hit = i_ds_rd && is_core_addr(i_ds_addr);
    case (i_ds_addr)
      ADDR_ACC:        next_rdata = acc;
      ADDR_IDX_FIRST:  next_rdata = idx1;
      ADDR_IDX_SECOND: next_rdata = idx2;
      ADDR_SHD_FIRST:  next_rdata = shd1;
      ADDR_SHD_SECOND: next_rdata = shd2;
      default:         next_rdata = '0;     // Unmapped reads zero
    endcase
    if (!i_ds_rd) begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ds_rdata <= '0;
      o_ds_hit   <= 1'b0;
    end else begin
      o_ds_rdata <= next_rdata;
      o_ds_hit   <= next_hit;
    end
  end

  // ---- Program counter, context and flags
  logic [PC_W-1:0] pc, next_pc;           // Program counter
  mcr_ctx_t        ctx, next_ctx;         // Active context
  mcr_ctx_t        hist0, next_hist0;     // Context to return to
  mcr_ctx_t        hist1, next_hist1;     // One deeper
  logic            flag_c [3];            // Carry per context
  logic            flag_z [3];            // Zero per context
  logic            next_flag_c [3];
  logic            next_flag_z [3];
  logic            push, pop;             // Stack requests

  // Sequencer step; only the active pair is ever written
  always_comb begin
    next_pc     = pc;
    next_ctx    = ctx;
    next_hist0  = hist0;
    next_hist1  = hist1;
    next_flag_c = flag_c;
    next_flag_z = flag_z;
    push        = 1'b0;
    pop         = 1'b0;
    if (strobe) begin
      // Flags belong to the instruction ending now
      if (i_c_we) begin
        next_flag_c[ctx] = i_c_val;
      end
      if (i_z_we) begin
        next_flag_z[ctx] = (i_alu_result == '0);
      end
      case (i_pc_op)
        PC_HOLD: ;
        PC_INC:  next_pc = pc_plus_one(pc);
        PC_JUMP: next_pc = i_pc_target;
        PC_CALL: begin
          push    = 1'b1;
          next_pc = i_pc_target;
        end
        PC_REL:  next_pc = pc + {{4{i_rel_offset[7]}},
                                 i_rel_offset};
        PC_IRQ, PC_NMI: begin
          push       = 1'b1;
          next_pc    = i_pc_target;
          next_hist1 = hist0;
          next_hist0 = ctx;
          next_ctx   = (i_pc_op == PC_NMI) ? CTX_NMI
                                           : CTX_IRQ;
        end
        PC_RET, PC_RETURN_FROM_IRQ: begin
          if (stk.empty) begin
            next_pc = pc_plus_one(pc);
          end else begin
            pop     = 1'b1;
            next_pc = stk.top;
          end
          if (i_pc_op == PC_RETURN_FROM_IRQ) begin
            next_ctx   = hist0;
            next_hist0 = hist1;
            next_hist1 = CTX_NORMAL;
          end
        end
        default: ;                                      // Undefined op
      endcase
    end
  end

  assign stk.push      = push;
  assign stk.pop       = pop;
  assign stk.push_data = pc;

  // Reset enters the non-maskable context at the vector
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pc    <= RESET_VEC;
      ctx   <= CTX_NMI;
      hist0 <= CTX_NORMAL;
      hist1 <= CTX_NORMAL;
      for (int i = 0; i < 3; i++) begin
        flag_c[i] <= 1'b0;
        flag_z[i] <= 1'b0;
      end
    end else begin
      pc     <= next_pc;
      ctx    <= next_ctx;
      hist0  <= next_hist0;
      hist1  <= next_hist1;
      flag_c <= next_flag_c;
      flag_z <= next_flag_z;
    end
  end

  assign o_pc          = pc;
  assign o_prog_addr   = {bank, pc};
  assign o_ctx         = ctx;
  assign o_carry       = flag_c[ctx];
  assign o_zero        = flag_z[ctx];
  assign o_acc         = acc;
  assign o_idx_first   = idx1;
  assign o_idx_second  = idx2;
  assign o_shd_first   = shd1;
  assign o_shd_second  = shd2;
  assign o_stack_depth = stk.depth;

  // ---- Checks
  sequence s_quiet_gap;
    (!strobe)[*8] ##1 (!strobe)[*4];
  endsequence

  property p_div13;
    strobe |=> s_quiet_gap ##1 strobe;
  endproperty
  a_div13 : assert property (p_div13)
    else $error("machine cycle not 13 clocks");

  property p_reset_state;
    $past(i_rst) |-> pc == RESET_VEC && ctx == CTX_NMI &&
                     stk.depth == '0;
  endproperty
  a_reset_state : assert property (p_reset_state)
    else $error("wrong state after reset");

  property p_pc_inc;
    (strobe && i_pc_op == PC_INC) |=> pc == $past(pc) + 12'h001;
  endproperty
  a_pc_inc : assert property (p_pc_inc)
    else $error("pc did not increment");

  property p_pc_rel;
    (strobe && i_pc_op == PC_REL) |=>
      pc == $past(pc) + {{4{$past(i_rel_offset[7])}},
                         $past(i_rel_offset)};
  endproperty
  a_pc_rel : assert property (p_pc_rel)
    else $error("relative branch wrong");

  property p_nmi_enter;
    (strobe && i_pc_op == PC_NMI) |=>
      ctx == CTX_NMI && hist0 == $past(ctx) &&
      pc == $past(i_pc_target);
  endproperty
  a_nmi_enter : assert property (p_nmi_enter)
    else $error("nmi entry wrong");

  // Normal pair sits untouched for as long as service runs
  property p_pair_kept;
    ctx != CTX_NORMAL |=>
      flag_c[CTX_NORMAL] == $past(flag_c[CTX_NORMAL]) &&
      flag_z[CTX_NORMAL] == $past(flag_z[CTX_NORMAL]);
  endproperty
  a_pair_kept : assert property (p_pair_kept)
    else $error("idle flag pair changed");

  property p_zero_flag;
    (strobe && i_z_we && i_pc_op == PC_INC) |=>
      o_zero == ($past(i_alu_result) == '0);
  endproperty
  a_zero_flag : assert property (p_zero_flag)
    else $error("zero flag wrong");

  property p_acc_map;
    (i_ds_wr && i_ds_addr == ADDR_ACC && !i_acc_we) |=>
      o_acc == $past(i_ds_wdata);
  endproperty
  a_acc_map : assert property (p_acc_map)
    else $error("accumulator write via data space lost");

  property p_ret_empty;
    (strobe && i_pc_op == PC_RET && stk.empty) |=>
      pc == $past(pc) + 12'h001 && stk.empty;
  endproperty
  a_ret_empty : assert property (p_ret_empty)
    else $error("return on empty stack misbehaved");

  // Call then return on the next step hands back the caller
  property p_call_ret;
    (strobe && push && stk.depth != DEPTH_W'(STACK_DEPTH)) ##1
      s_quiet_gap ##1 (strobe && pop) |=>
      pc == $past(pc, 14) && stk.depth == $past(stk.depth, 14) &&
      stk.top == $past(stk.top, 14);
  endproperty
  a_call_ret : assert property (p_call_ret)
    else $error("return did not undo the last call");
endmodule : mcr_core_regs

// *** rtl/mcr_pkg.sv ***
// Shared constants and types for the core register block
package mcr_pkg;
  localparam int PC_W        = 12;     // Program counter width
  localparam int DATA_W      = 8;      // Data register width
  localparam int STACK_DEPTH = 6;      // Return stack levels
  localparam int DEPTH_W     = 3;      // Stack fill counter width
  localparam int MCYC_DIV    = 13;     // Clock cycles per machine cycle
  localparam int DIV_W       = 4;      // Divider counter width
  localparam int BANK_W      = 2;      // Program bank select width

  // Data-space addresses of the mapped core registers
  localparam logic [7:0] ADDR_IDX_FIRST   = 8'h80;
  localparam logic [7:0] ADDR_IDX_SECOND  = 8'h81;
  localparam logic [7:0] ADDR_SHD_FIRST   = 8'h82;
  localparam logic [7:0] ADDR_SHD_SECOND  = 8'h83;
  localparam logic [7:0] ADDR_ACC         = 8'hff;

  localparam logic [11:0] RESET_VEC = 12'hffe;  // Reset vector
  localparam logic [7:0]  REG_RST   = 8'h00;    // Data register reset
  localparam logic [1:0]  BANK_RST  = 2'h0;     // Bank select reset

  // Next-address source for the program counter
  typedef enum logic [3:0] {
    PC_HOLD, PC_INC, PC_JUMP, PC_CALL, PC_REL,
    PC_IRQ, PC_NMI, PC_RET, PC_RETURN_FROM_IRQ
  } mcr_pc_op_t;

  // Execution context selecting the flag pair
  typedef enum logic [1:0] {
    CTX_NORMAL, CTX_IRQ, CTX_NMI
  } mcr_ctx_t;
endpackage : mcr_pkg

// *** rtl/mcr_ret_stack.sv ***
// Six-level saturating hardware return stack
`timescale 1ns/1ps
module mcr_ret_stack
  import mcr_pkg::*;
(
  input  wire logic i_clk,       // Core clock
  input  wire logic i_rst,       // Sync reset, high
  mcr_stk_if.stack  s            // Push/pop port
);
  logic [PC_W-1:0]    lvl      [STACK_DEPTH];  // Stack levels
  logic [PC_W-1:0]    next_lvl [STACK_DEPTH];
  logic [DEPTH_W-1:0] depth;                   // Fill count
  logic [DEPTH_W-1:0] next_depth;

  assign s.top   = lvl[0];
  assign s.empty = (depth == '0);
  assign s.depth = depth;

  // Shift logic; push wins if both ever arrive together
  always_comb begin
    next_lvl   = lvl;
    next_depth = depth;
    if (s.push) begin
      // Oldest level falls off the bottom
      for (int i = STACK_DEPTH - 1; i > 0; i--) begin
        next_lvl[i] = lvl[i-1];
      end
      next_lvl[0] = s.push_data;
      if (depth != DEPTH_W'(STACK_DEPTH)) begin
        next_depth = depth + 1'b1;
      end
    end else if (s.pop && depth != '0) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        next_lvl[i] = lvl[i+1];
      end
      next_lvl[STACK_DEPTH-1] = '0;
      next_depth = depth - 1'b1;
    end
  end

  // Registers; reset empties the stack
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        lvl[i] <= '0;
      end
      depth <= '0;
    end else begin
      lvl   <= next_lvl;
      depth <= next_depth;
    end
  end

  property p_stk_sat;
    @(posedge i_clk) disable iff (i_rst)
    (s.push && depth == DEPTH_W'(STACK_DEPTH)) |=> depth == $past(depth);
  endproperty
  a_stk_sat : assert property (p_stk_sat)
    else $error("stack depth left saturation");

  // Every real pop moves the second level up and drops one from the count
  property p_stk_pop;
    @(posedge i_clk) disable iff (i_rst)
    (s.pop && !s.push && depth != '0) |=>
      lvl[0] == $past(lvl[1]) && depth == $past(depth) - 1'b1;
  endproperty
  a_stk_pop : assert property (p_stk_pop)
    else $error("pop did not shift the stack up");
endmodule : mcr_ret_stack

// *** rtl/mcr_stk_if.sv ***
// Link between core and return stack
`timescale 1ns/1ps
interface mcr_stk_if;
  import mcr_pkg::*;
  logic                push;       // Shift deeper, load first level
  logic                pop;        // Shift back up one level
  logic [PC_W-1:0]     push_data;  // Address pushed
  logic [PC_W-1:0]     top;        // First level
  logic                empty;      // No level held
  logic [DEPTH_W-1:0]  depth;      // Levels held
  modport core  (output push, pop, push_data, input top, empty, depth);
  modport stack (input push, pop, push_data, output top, empty, depth);
endinterface : mcr_stk_if

// *** testbench/mcr_mem_model.sv ***
// Behavioural data RAM standing on the far side of the data-space bus
`timescale 1ns/1ps
module mcr_mem_model
  import mcr_pkg::*;
(
  input  wire logic              i_clk,    // Core clock
  input  wire logic [7:0]        i_addr,   // Data address
  input  wire logic              i_wr,     // Write strobe
  input  wire logic              i_rd,     // Read strobe
  input  wire logic [DATA_W-1:0] i_wdata,  // Write data
  output logic [DATA_W-1:0]      o_rdata,  // Read data, next clock
  output logic                   o_valid   // Read answered this cycle
);
  logic [DATA_W-1:0] mem [0:255];          // Plain byte store
  logic [DATA_W-1:0] last;                 // Last value read out

  // Core registers answer for their own addresses, so skip them here
  function automatic logic is_core(input logic [7:0] a);
    return a inside {ADDR_IDX_FIRST, ADDR_IDX_SECOND, ADDR_SHD_FIRST,
                     ADDR_SHD_SECOND, ADDR_ACC};
  endfunction : is_core

  initial begin
    last    = 8'h00;
    o_rdata = 8'h00;
    o_valid = 1'b0;
  end

  // Released bus shows the inverse of the last value, never a stale copy
  always @(posedge i_clk) begin
    if (i_wr && !is_core(i_addr)) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_rd && !is_core(i_addr)) begin
      last    = mem[i_addr];
      o_rdata <= mem[i_addr];
      o_valid <= 1'b1;
    end else begin
      o_rdata <= ~last;
      o_valid <= 1'b0;
    end
  end
endmodule : mcr_mem_model

// *** testbench/testbench.sv ***
// Self-checking bench for the core register block
`timescale 1ns/1ps
module testbench
  import mcr_pkg::*;
;
  logic              i_clk, i_rst, i_c_we, i_c_val, i_z_we, i_acc_we;
  logic              i_ds_wr, i_ds_rd, i_bank_we;
  mcr_pc_op_t        i_pc_op;
  logic [PC_W-1:0]   i_pc_target;
  logic [7:0]        i_rel_offset, i_alu_result, i_acc_wdata;
  logic [7:0]        i_ds_addr, i_ds_wdata, o_ds_rdata, o_acc, mem_rdata;
  logic [7:0]        o_idx_first, o_idx_second, o_shd_first, o_shd_second;
  logic [BANK_W-1:0] i_bank_wdata;
  logic              o_ds_hit, o_mcycle, o_carry, o_zero, mem_valid;
  logic [PC_W-1:0]   o_pc;
  logic [13:0]       o_prog_addr;
  mcr_ctx_t          o_ctx;
  logic [2:0]        o_stack_depth;
  int                errors, cmp_count, cyc, last;
  logic [7:0]        addrs [5];          // Mapped core addresses
  logic [7:0]        regs  [5];          // Their visible values

  mcr_core_regs u_mcr_core_regs (
    .i_clk(i_clk), .i_rst(i_rst), .i_pc_op(i_pc_op),
    .i_pc_target(i_pc_target), .i_rel_offset(i_rel_offset),
    .i_c_we(i_c_we), .i_c_val(i_c_val), .i_z_we(i_z_we),
    .i_alu_result(i_alu_result), .i_acc_we(i_acc_we),
    .i_acc_wdata(i_acc_wdata), .i_ds_addr(i_ds_addr), .i_ds_wr(i_ds_wr),
    .i_ds_rd(i_ds_rd), .i_ds_wdata(i_ds_wdata), .o_ds_rdata(o_ds_rdata),
    .o_ds_hit(o_ds_hit), .i_bank_we(i_bank_we),
    .i_bank_wdata(i_bank_wdata), .o_mcycle(o_mcycle), .o_pc(o_pc),
    .o_prog_addr(o_prog_addr), .o_ctx(o_ctx), .o_carry(o_carry),
    .o_zero(o_zero), .o_acc(o_acc), .o_idx_first(o_idx_first),
    .o_idx_second(o_idx_second), .o_shd_first(o_shd_first),
    .o_shd_second(o_shd_second), .o_stack_depth(o_stack_depth));
  mcr_mem_model u_mcr_mem_model (.i_clk(i_clk), .i_addr(i_ds_addr),
    .i_wr(i_ds_wr), .i_rd(i_ds_rd), .i_wdata(i_ds_wdata),
    .o_rdata(mem_rdata), .o_valid(mem_valid));

  always #12.5 i_clk = ~i_clk;
  assign regs = '{o_idx_first, o_idx_second, o_shd_first, o_shd_second,
                  o_acc};

  // Uniform compare; values widened so unknowns still mismatch
  task automatic chk(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Strobe spacing watched on the falling edge, away from updates
  always @(negedge i_clk) begin
    cyc++;
    if (i_rst) last = 0;
    else if (o_mcycle) begin
      if (last != 0) chk("strobe gap", 16'(MCYC_DIV), 16'(cyc - last));
      last = cyc;
    end
  end

  // One sequencer step, launched on the next strobe
  task automatic op(input mcr_pc_op_t o, input logic [11:0] t = 12'h000,
                    input logic [7:0] f = 8'h00, input logic [1:0] c = 2'b00,
                    input logic zw = 1'b0, input logic [7:0] r = 8'h00);
    int n;
    for (n = 0; n < 20 && o_mcycle !== 1'b1; n++) @(posedge i_clk) #2;
    chk("strobe seen", 16'h1, 16'(o_mcycle));
    i_pc_op = o; i_pc_target = t; i_rel_offset = f;
    {i_c_we, i_c_val} = c; i_z_we = zw; i_alu_result = r;
    @(posedge i_clk) #2;
    i_pc_op = PC_HOLD; i_c_we = 1'b0; i_z_we = 1'b0;
  endtask : op

  // Visible sequencer state
  task automatic st(input logic [11:0] p, input mcr_ctx_t x,
                    input logic [2:0] d, input logic c, z);
    chk("pc", 16'(p), 16'(o_pc));
    chk("ctx", 16'(x), 16'(o_ctx));
    chk("depth", 16'(d), 16'(o_stack_depth));
    chk("carry", 16'(c), 16'(o_carry));
    chk("zero", 16'(z), 16'(o_zero));
  endtask : st

  // Write; an idle edge after it keeps the next strobe off this step
  task automatic ds_wr(input logic [7:0] a, d);
    i_ds_addr = a; i_ds_wdata = d; i_ds_wr = 1'b1;
    @(posedge i_clk) #2;
    i_ds_wr = 1'b0;
    @(posedge i_clk) #2;
  endtask : ds_wr

  // Read; core answer or the far-side store picked by the hit flag
  task automatic ds_rd(input logic [7:0] a, e, input logic h);
    i_ds_addr = a; i_ds_rd = 1'b1;
    @(posedge i_clk) #2;
    i_ds_rd = 1'b0;
    chk("hit", 16'(h), 16'(o_ds_hit));
    chk("rdata", 16'(e), 16'(o_ds_hit ? o_ds_rdata : mem_rdata));
    if (!h) chk("core rdata", 16'h0, 16'(o_ds_rdata));
    @(posedge i_clk) #2;
  endtask : ds_rd

  initial begin
    #(25 * 5000);
    errors++;
    give_verdict();
  end

  initial begin
    i_clk = 0; i_rst = 1; i_pc_op = PC_HOLD; i_pc_target = '0;
    i_rel_offset = '0; i_c_we = 0; i_c_val = 0; i_z_we = 0;
    i_alu_result = '0; i_acc_we = 0; i_acc_wdata = '0; i_ds_addr = '0;
    i_ds_wr = 0; i_ds_rd = 0; i_ds_wdata = '0; i_bank_we = 0;
    i_bank_wdata = '0; errors = 0; cmp_count = 0; cyc = 0; last = 0;
    addrs = '{ADDR_IDX_FIRST, ADDR_IDX_SECOND, ADDR_SHD_FIRST,
              ADDR_SHD_SECOND, ADDR_ACC};
    repeat (5) @(posedge i_clk);
    #2 i_rst = 0;
    st(12'hffe, CTX_NMI, 0, 0, 0);
    op(PC_INC, 0, 0, 2'b11, 1, 8'h00);
    st(12'hfff, CTX_NMI, 0, 1, 1);
    op(PC_RETURN_FROM_IRQ);
    st(12'h000, CTX_NORMAL, 0, 0, 0);
    op(PC_JUMP, 12'h100, 0, 2'b11, 1, 8'h05);
    st(12'h100, CTX_NORMAL, 0, 1, 0);
    op(PC_INC);
    chk("pc inc", 16'h101, 16'(o_pc));
    op(PC_REL, 0, 8'hfe);
    chk("pc rel back", 16'h0ff, 16'(o_pc));
    op(PC_REL, 0, 8'h05);
    chk("pc rel fwd", 16'h104, 16'(o_pc));
    op(PC_CALL, 12'h200);
    st(12'h200, CTX_NORMAL, 1, 1, 0);
    op(PC_IRQ, 12'h300);
    st(12'h300, CTX_IRQ, 2, 0, 0);
    op(PC_INC, 0, 0, 2'b11, 1, 8'h00);
    st(12'h301, CTX_IRQ, 2, 1, 1);
    op(PC_NMI, 12'h3f0);
    st(12'h3f0, CTX_NMI, 3, 1, 1);
    op(PC_HOLD, 0, 0, 2'b10, 1, 8'h01);
    st(12'h3f0, CTX_NMI, 3, 0, 0);
    op(PC_RETURN_FROM_IRQ);
    st(12'h301, CTX_IRQ, 2, 1, 1);
    op(PC_RETURN_FROM_IRQ);
    st(12'h200, CTX_NORMAL, 1, 1, 0);
    op(PC_RET);
    st(12'h104, CTX_NORMAL, 0, 1, 0);
    for (int i = 0; i < 7; i++) begin
      op(PC_CALL, 12'h010 + 12'(i));
      chk("depth sat", 16'(i < 6 ? i + 1 : 6), 16'(o_stack_depth));
    end
    for (int i = 0; i < 6; i++) begin
      op(PC_RET);
      chk("pop pc", 16'(12'h015 - 12'(i)), 16'(o_pc));
    end
    op(PC_RET);
    st(12'h011, CTX_NORMAL, 0, 1, 0);
    i_bank_we = 1; i_bank_wdata = 2'h2;
    @(posedge i_clk) #2;
    i_bank_we = 0;
    chk("prog addr", 16'h2011, 16'(o_prog_addr));
    for (int i = 0; i < 5; i++) ds_wr(addrs[i], 8'ha1 + 8'(i));
    for (int i = 0; i < 5; i++) begin
      chk("reg out", 16'(8'ha1 + 8'(i)), 16'(regs[i]));
      ds_rd(addrs[i], 8'ha1 + 8'(i), 1);
    end
    ds_wr(8'h84, 8'h77);
    ds_rd(8'h84, 8'h77, 0);
    chk("acc kept", 16'ha5, 16'(o_acc));
    i_acc_we = 1; i_acc_wdata = 8'h3c;
    ds_wr(ADDR_ACC, 8'h99);
    i_acc_we = 0;
    chk("acc direct", 16'h3c, 16'(o_acc));
    op(PC_CALL, 12'h050);
    op(PC_RET);
    st(12'h011, CTX_NORMAL, 0, 1, 0);
    op(PC_CALL, 12'h050);
    st(12'h050, CTX_NORMAL, 1, 1, 0);
    i_rst = 1;
    @(posedge i_clk) #2;
    i_rst = 0;
    st(12'hffe, CTX_NMI, 0, 0, 0);
    op(PC_INC);
    chk("pc after rst", 16'hfff, 16'(o_pc));
    give_verdict();
  end
endmodule : testbench
